//--- common/mre_pkg.sv
// shared constants, state encoding and register layout of the executor
package mre_pkg;

  // instruction word fields, bit 35 is the sign / leftmost bit
  localparam int OP_MSB = 35;
  localparam int OP_LSB = 30;
  localparam int IND_POS = 29;
  localparam int SUB_MSB = 29;
  localparam int SUB_LSB = 27;
  localparam int X_MSB = 26;
  localparam int X_LSB = 18;
  localparam int SIGN_POS = 35;

  // operation codes (six bits, digits 0 and 1)
  localparam logic [5:0] OP_AND = 6'h02;
  localparam logic [5:0] OP_IOR = 6'h04;
  localparam logic [5:0] OP_XOR = 6'h06;
  localparam logic [5:0] OP_LIR = 6'h0c;
  localparam logic [5:0] OP_DIA = 6'h0e;
  localparam logic [5:0] OP_LAC = 6'h10;
  localparam logic [5:0] OP_LIO = 6'h12;
  localparam logic [5:0] OP_DAC = 6'h14;
  localparam logic [5:0] OP_DAP = 6'h16;
  localparam logic [5:0] OP_DIP = 6'h18;
  localparam logic [5:0] OP_DIO = 6'h1a;
  localparam logic [5:0] OP_ADD = 6'h20;
  localparam logic [5:0] OP_SUB = 6'h22;
  localparam logic [5:0] OP_SPX = 6'h24;
  localparam logic [5:0] OP_SNX = 6'h26;
  localparam logic [5:0] OP_SAD = 6'h28;
  localparam logic [5:0] OP_SAS = 6'h2a;
  localparam logic [5:0] OP_MUL = 6'h2c;
  localparam logic [5:0] OP_DIV = 6'h2e;
  localparam logic [5:0] OP_JMP = 6'h30;
  localparam logic [5:0] OP_JSP = 6'h32;
  localparam logic [5:0] OP_ROT_L = 6'h36;
  localparam logic [5:0] OP_ROT_R = 6'h37;
  localparam logic [2:0] SUB_ROT_AC = 3'h1;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_IA = 8'h0c;
  localparam logic [7:0] REG_AC_LO = 8'h10;
  localparam logic [7:0] REG_AC_HI = 8'h14;
  localparam logic [7:0] REG_IO_LO = 8'h18;
  localparam logic [7:0] REG_IO_HI = 8'h1c;

  // control and status bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_STEP = 2;
  localparam int STAT_RUN = 0;
  localparam int STAT_OVF = 1;
  localparam int STAT_BUSY = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [14:0] DIV_STEPS = 15'h0023;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_INDEX, S_RESOLVE, S_DEFER, S_OPER, S_EXEC,
    S_XREAD, S_WRITE, S_ROT, S_DIV
  } mre_state_type;

  typedef struct packed {
    mre_state_type st;
    logic run;
    logic step;
    logic defer;
    logic skip;
    logic ovf;
    logic [14:0] pc;
    logic [14:0] addr;
    logic [14:0] ia;
    logic [14:0] cnt;
    logic [35:0] ir;
    logic [35:0] opnd;
    logic [35:0] ac;
    logic [35:0] io;
    logic [35:0] rem;
    logic [34:0] quo;
    logic mem_req;
    logic mem_we;
    logic [14:0] mem_addr;
    logic [35:0] mem_wdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mre_regs_type;

  localparam mre_regs_type MRE_RESET = '0;

endpackage : mre_pkg

//--- design/mre_exec.sv
// memory reference and accumulator rotate executor with register slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Functional notes
// - 40 adds operand, sets overflow
// - 42 subtracts operand, sets overflow
// - 54 multiplies, high to accumulator, low io
// - 56 divides seventy bit accumulator:io dividend
// - quotient in io, remainder keeps dividend sign
// - too large dividend sets overflow, no divide
// - 02 bitwise and into accumulator
// - 06 bitwise exclusive or into accumulator
// - 04 bitwise inclusive or into accumulator
// - 20 loads operand into accumulator
// - 24 stores accumulator at effective address
// - 26 stores accumulator digits six to eleven
// - 30 stores accumulator digits zero to five
// - 22 loads operand into io register
// - 32 stores io register at effective address
// - 60 jumps to effective address
// - 62 saves next address in index adder, jumps
// - 50 skips on differ, 52 on equal
// - 46/44 step index location, skip on sign
// - 14 loads address field into index location
// - 16 deposits index adder into address location
// - 671/661 rotate accumulator ring right/left
// - nonzero index field adds location low digits
// - bit six set defers through fetched words
// - overflow sticky, cleared only by start
// - words are ones complement, sign leftmost
module mre_exec
  import mre_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // register bus read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core memory port
  output logic mem_req,
  output logic mem_we,
  output logic [14:0] mem_addr,
  output logic [35:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [35:0] mem_rdata,
  // status
  output logic running,
  output logic overflow
);

  mre_regs_type q;
  mre_regs_type n;
  logic fin;
  logic quiet;
  logic [31:0] wtmp;
  logic [5:0] op;
  logic [36:0] add_res;
  logic [36:0] sub_res;
  logic [35:0] ac_ror;
  logic [35:0] ac_rol;
  logic [34:0] am;
  logic [34:0] bm;
  logic [69:0] prod;
  logic msign;
  logic [34:0] ah;
  logic [34:0] al;
  logic [35:0] dtrial;
  logic dge;
  logic [14:0] step_sum;

  // ones complement sum with end-around carry
  function automatic logic [36:0] oc_add36(input logic [35:0] a,
                                           input logic [35:0] b);
    logic [36:0] raw;
    logic [35:0] r;
    raw = {1'b0, a} + {1'b0, b};
    r = raw[35:0] + {35'h0, raw[36]};
    return {(a[35] == b[35]) && (r[35] != a[35]), r};
  endfunction : oc_add36

  // fifteen bit index adder, also ones complement
  function automatic logic [14:0] oc_add15(input logic [14:0] a,
                                           input logic [14:0] b);
    logic [15:0] raw;
    raw = {1'b0, a} + {1'b0, b};
    return raw[14:0] + {14'h0, raw[15]};
  endfunction : oc_add15

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // magnitude of a ones complement word
  function automatic logic [34:0] mag(input logic [35:0] w);
    return w[SIGN_POS] ? ~w[34:0] : w[34:0];
  endfunction : mag

  assign op = q.ir[OP_MSB:OP_LSB];
  assign add_res = oc_add36(q.ac, q.opnd);
  assign sub_res = oc_add36(q.ac, ~q.opnd);
  assign ac_ror = {q.ac[0], q.ac[35:1]};
  assign ac_rol = {q.ac[34:0], q.ac[35]};
  assign am = mag(q.ac);
  assign bm = mag(q.opnd);
  assign prod = {35'h0, am} * {35'h0, bm};
  assign msign = q.ac[SIGN_POS] ^ q.opnd[SIGN_POS];
  assign ah = am;
  assign al = q.ac[SIGN_POS] ? ~q.io[34:0] : q.io[34:0];
  assign dtrial = {q.rem[34:0], q.quo[34]};
  assign dge = dtrial >= {1'b0, bm};
  assign step_sum = oc_add15(q.opnd[14:0], q.ir[14:0]);
  // registers software may load only while nothing executes
  assign quiet = !q.run && !q.step && (q.st == S_IDLE);

  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign mem_req = q.mem_req;
  assign mem_we = q.mem_we;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;
  assign running = q.run;
  assign overflow = q.ovf;

  always_comb begin
    n = q;
    fin = 1'b0;
    wtmp = 32'h0;
    // bus write: address and data latched in either order
    if (awvalid && awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (q.awaddr == REG_CTRL) begin
        if (q.wstrb[0] && q.wdata[CTRL_START]) begin
          n.run = 1'b1;
          n.ovf = 1'b0;
        end
        if (q.wstrb[0] && q.wdata[CTRL_STOP]) begin
          n.run = 1'b0;
        end
        if (q.wstrb[0] && q.wdata[CTRL_STEP]) begin
          n.step = 1'b1;
        end
      end else if (q.awaddr == REG_PC) begin
        wtmp = wmerge({17'h0, q.pc}, q.wdata, q.wstrb);
        if (quiet) n.pc = wtmp[14:0];
      end else if (q.awaddr == REG_AC_LO) begin
        wtmp = wmerge(q.ac[31:0], q.wdata, q.wstrb);
        if (quiet) n.ac[31:0] = wtmp;
      end else if (q.awaddr == REG_AC_HI) begin
        wtmp = wmerge({28'h0, q.ac[35:32]}, q.wdata, q.wstrb);
        if (quiet) n.ac[35:32] = wtmp[3:0];
      end else if (q.awaddr == REG_IO_LO) begin
        wtmp = wmerge(q.io[31:0], q.wdata, q.wstrb);
        if (quiet) n.io[31:0] = wtmp;
      end else if (q.awaddr == REG_IO_HI) begin
        wtmp = wmerge({28'h0, q.io[35:32]}, q.wdata, q.wstrb);
        if (quiet) n.io[35:32] = wtmp[3:0];
      end else if (q.awaddr != REG_STATUS && q.awaddr != REG_IA) begin
        n.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // bus read
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      if (araddr == REG_CTRL) begin
        n.rdata[CTRL_STEP] = q.step;
      end else if (araddr == REG_STATUS) begin
        n.rdata[STAT_RUN] = q.run;
        n.rdata[STAT_OVF] = q.ovf;
        n.rdata[STAT_BUSY] = q.st != S_IDLE;
      end else if (araddr == REG_PC) begin
        n.rdata = {17'h0, q.pc};
      end else if (araddr == REG_IA) begin
        n.rdata = {17'h0, q.ia};
      end else if (araddr == REG_AC_LO) begin
        n.rdata = q.ac[31:0];
      end else if (araddr == REG_AC_HI) begin
        n.rdata = {28'h0, q.ac[35:32]};
      end else if (araddr == REG_IO_LO) begin
        n.rdata = q.io[31:0];
      end else if (araddr == REG_IO_HI) begin
        n.rdata = {28'h0, q.io[35:32]};
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    // a completed memory transfer drops the request unless relaunched
    if (q.mem_req && mem_ack) begin
      n.mem_req = 1'b0;
      n.mem_we = 1'b0;
    end
    case (q.st)
      S_IDLE: begin
        if (q.run || q.step) begin
          n.step = 1'b0;
          n.mem_req = 1'b1;
          n.mem_addr = q.pc;
          n.st = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          n.ir = mem_rdata;
          n.pc = q.pc + 15'h0001;
          n.addr = mem_rdata[14:0];
          n.defer = mem_rdata[IND_POS];
          n.skip = 1'b0;
          case (mem_rdata[OP_MSB:OP_LSB])
            OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_AND, OP_XOR, OP_IOR,
            OP_LAC, OP_DAC, OP_DAP, OP_DIP, OP_LIO, OP_DIO, OP_JMP,
            OP_JSP, OP_SAD, OP_SAS: begin
              // index location read when field nonzero
              if (mem_rdata[X_MSB:X_LSB] != 9'h000) begin
                n.mem_req = 1'b1;
                n.mem_addr = {6'h00, mem_rdata[X_MSB:X_LSB]};
                n.st = S_INDEX;
              end else begin
                n.st = S_RESOLVE;
              end
            end
            OP_SNX, OP_SPX, OP_LIR: begin
              n.addr = {6'h00, mem_rdata[X_MSB:X_LSB]};
              n.mem_req = 1'b1;
              n.mem_addr = {6'h00, mem_rdata[X_MSB:X_LSB]};
              n.st = S_XREAD;
            end
            OP_DIA: begin
              n.mem_req = 1'b1;
              n.mem_addr = mem_rdata[14:0];
              n.st = S_XREAD;
            end
            OP_ROT_L, OP_ROT_R: begin
              n.cnt = mem_rdata[14:0];
              if (mem_rdata[SUB_MSB:SUB_LSB] == SUB_ROT_AC) begin
                n.st = S_ROT;
              end else begin
                fin = 1'b1;
              end
            end
            default: fin = 1'b1;
          endcase
        end
      end
      S_INDEX: begin
        if (mem_ack) begin
          // effective address through the index adder
          n.addr = oc_add15(q.addr, mem_rdata[14:0]);
          n.st = S_RESOLVE;
        end
      end
      S_RESOLVE: begin
        if (q.defer) begin
          n.mem_req = 1'b1;
          n.mem_addr = q.addr;
          n.st = S_DEFER;
        end else if (op == OP_JMP) begin
          n.pc = q.addr;
          n.st = S_IDLE;
        end else if (op == OP_JSP) begin
          n.ia = q.pc;
          n.pc = q.addr;
          n.st = S_IDLE;
        end else if (op == OP_DAC || op == OP_DIO) begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = q.addr;
          n.mem_wdata = (op == OP_DAC) ? q.ac : q.io;
          n.st = S_WRITE;
        end else begin
          n.mem_req = 1'b1;
          n.mem_addr = q.addr;
          n.st = S_OPER;
        end
      end
      S_DEFER: begin
        if (mem_ack) begin
          // repeat while the fetched word is deferred
          n.addr = mem_rdata[14:0];
          n.defer = mem_rdata[IND_POS];
          n.st = S_RESOLVE;
        end
      end
      S_OPER: begin
        if (mem_ack) begin
          n.opnd = mem_rdata;
          n.st = S_EXEC;
        end
      end
      S_EXEC: begin
        fin = 1'b1;
        case (op)
          OP_ADD: begin
            // sum, overflow set here and also by subtract and divide
            n.ac = add_res[35:0];
            if (add_res[36]) n.ovf = 1'b1;
          end
          OP_SUB: begin
            n.ac = sub_res[35:0];
            if (sub_res[36]) n.ovf = 1'b1;
          end
          OP_MUL: begin
            n.ac = {msign, msign ? ~prod[69:35] : prod[69:35]};
            n.io = {msign, msign ? ~prod[34:0] : prod[34:0]};
          end
          OP_DIV: begin
            // quotient would not fit, also divide by zero
            if (ah >= bm) begin
              n.ovf = 1'b1;
            end else begin
              // high part from accumulator, low from io
              fin = 1'b0;
              n.rem = {1'b0, ah};
              n.quo = al;
              n.cnt = DIV_STEPS;
              n.st = S_DIV;
            end
          end
          OP_AND: n.ac = q.ac & q.opnd;
          OP_XOR: n.ac = q.ac ^ q.opnd;
          OP_IOR: n.ac = q.ac | q.opnd;
          OP_LAC: n.ac = q.opnd;
          OP_LIO: n.io = q.opnd;
          OP_DAP, OP_DIP: begin
            fin = 1'b0;
            n.mem_req = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = q.addr;
            n.mem_wdata = (op == OP_DAP) ? {q.opnd[35:18], q.ac[17:0]}
                                         : {q.ac[35:18], q.opnd[17:0]};
            n.st = S_WRITE;
          end
          OP_SAD: n.skip = q.ac != q.opnd;
          OP_SAS: n.skip = q.ac == q.opnd;
          default: n.skip = 1'b0;
        endcase
      end
      S_XREAD: begin
        if (mem_ack) begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = q.mem_addr;
          n.st = S_WRITE;
          if (op == OP_LIR) begin
            // digit six cleared, left digits kept
            n.mem_wdata = {mem_rdata[35:18], 3'h0, q.ir[14:0]};
          end else if (op == OP_DIA) begin
            n.mem_wdata = {mem_rdata[35:18], 3'h0, q.ia};
          end else begin
            // step index, skip on sign of the sum
            n.ia = oc_add15(mem_rdata[14:0], q.ir[14:0]);
            n.mem_wdata = {mem_rdata[35:15],
                           oc_add15(mem_rdata[14:0], q.ir[14:0])};
            n.opnd = mem_rdata;
            n.skip = (op == OP_SNX) ? n.ia[14] : !n.ia[14];
          end
        end
      end
      S_WRITE: begin
        if (mem_ack) fin = 1'b1;
      end
      S_ROT: begin
        // one ring step per cycle, count from address
        if (q.cnt == 15'h0000) begin
          fin = 1'b1;
        end else begin
          n.ac = (op == OP_ROT_R) ? ac_ror : ac_rol;
          n.cnt = q.cnt - 15'h0001;
        end
      end
      S_DIV: begin
        if (q.cnt == 15'h0000) begin
          // signs applied after the magnitude divide
          n.io = {msign, msign ? ~q.quo : q.quo};
          n.ac = {q.ac[SIGN_POS],
                  q.ac[SIGN_POS] ? ~q.rem[34:0] : q.rem[34:0]};
          fin = 1'b1;
        end else begin
          // restoring step: slow but small, no 70 bit divider
          n.rem = dge ? dtrial - {1'b0, bm} : dtrial;
          n.quo = {q.quo[33:0], dge};
          n.cnt = q.cnt - 15'h0001;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (fin) begin
      // one already added at fetch, skip adds the second
      n.pc = n.pc + {14'h0, n.skip};
      n.skip = 1'b0;
      n.st = S_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= MRE_RESET;
    end else begin
      q <= n;
    end
  end

  ovf_sticky_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.ovf && !(q.aw_got && q.w_got && !q.bvalid)) |=> q.ovf)
    else $error("overflow flag dropped without start");
  add_result_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_EXEC && op == OP_ADD) |=>
      (q.ac == $past(add_res[35:0])) && (q.st == S_IDLE))
    else $error("add result wrong");
  sub_ovf_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_EXEC && op == OP_SUB && sub_res[36]) |=> q.ovf)
    else $error("subtract overflow not flagged");
  jump_pc_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_RESOLVE && !q.defer && op == OP_JMP) |=>
      q.pc == $past(q.addr))
    else $error("jump target not loaded");
  jsp_save_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_RESOLVE && !q.defer && op == OP_JSP) |=>
      (q.ia == $past(q.pc)) && (q.pc == $past(q.addr)))
    else $error("return address not saved");
  dac_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_RESOLVE && !q.defer && op == OP_DAC) |=>
      q.mem_we && q.mem_req && (q.mem_wdata == $past(q.ac)))
    else $error("accumulator store wrong");
  pc_advance_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (fin && q.st == S_EXEC && op == OP_SAS && q.ac == q.opnd) |=>
      q.pc == $past(q.pc) + 15'h0001)
    else $error("taken skip did not advance pc");
  rot_ring_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_ROT && q.cnt != 15'h0000 && op == OP_ROT_R) |=>
      q.ac == $past(ac_ror))
    else $error("right rotate wrong");
  div_refuse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_EXEC && op == OP_DIV && ah >= bm) |=>
      q.ovf && $stable(q.io) && $stable(q.ac) && q.st == S_IDLE)
    else $error("oversize divide not refused");
  div_length_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.st == S_EXEC && op == OP_DIV && ah < bm) |=>
      (q.st == S_DIV && q.cnt == DIV_STEPS) ##35
      (q.st == S_DIV && q.cnt == 15'h0000) ##1 (q.st == S_IDLE))
    else $error("divide length wrong");

endmodule : mre_exec

//--- tb/mre_mem_model.sv
// core memory model, alternating prompt and slow answers
`timescale 1ns/10ps
module mre_mem_model (
  // clock
  input wire logic aclk,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [35:0] mem_wdata,
  output logic mem_ack,
  output logic [35:0] mem_rdata
);
  logic [35:0] m [0:32767];
  logic [1:0] cnt;
  logic slow;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 36'h0;
    cnt = 2'h0;
    slow = 1'b0;
  end
  // data outside the ack cycle toggles so stale words never look valid
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else begin
        mem_ack <= 1'b1;
        mem_rdata <= m[mem_addr];
        if (mem_we) begin
          m[mem_addr] <= mem_wdata;
        end
        slow <= !slow;
        cnt <= slow ? 2'h0 : 2'h3;
      end
    end
  end
endmodule : mre_mem_model

//--- tb/tb_mre_exec.sv
// bench: single-steps one instruction at a time and checks state, then free runs a jump to itself and stops
`timescale 1ns/10ps
module tb_mre_exec;
  import mre_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic mem_req, mem_we, mem_ack, running, overflow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [14:0] mem_addr;
  logic [35:0] mem_wdata, mem_rdata;
  int num_errors, compares, cyc;
  localparam logic [35:0] A = 36'h1_2345_6789;
  localparam logic [35:0] O = 36'h5_5555_5555;
  localparam logic [14:0] P1 = 15'h41;
  localparam logic [14:0] P2 = 15'h42;

  mre_exec dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .running, .overflow);
  mre_mem_model mem (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  always #5 aclk = ~aclk;

  task conclude;
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  task chk(input logic [35:0] g, input logic [35:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // each channel holds until the rising edge that takes it
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bvalid;
      rsp = bresp;
    end
  endtask : wr

  task rd(input logic [7:0] a);
    logic done;
    araddr <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      done = rvalid;
      rd_d = rdata;
      rsp = rresp;
    end
  endtask : rd

  function automatic logic [35:0] w(input logic [5:0] op,
    input logic [8:0] x = 9'h0, input logic [14:0] y = 15'h80);
    return {op, 3'h0, x, 3'h0, y};
  endfunction : w

  // loads registers, steps one instruction at 0x40, operand at 0x80
  task t(input logic [35:0] iw, ac, op, eac, em,
    input logic [14:0] epc = P1, input logic ov = 1'b0,
    input logic [35:0] io = 36'h0, eio = 36'h0);
    logic [31:0] lo;
    logic c;
    mem.m[15'h40] = iw;
    mem.m[15'h80] = op;
    wr(REG_PC, 32'h40);
    wr(REG_AC_LO, ac[31:0]);
    wr(REG_AC_HI, {28'h0, ac[35:32]});
    wr(REG_IO_LO, io[31:0]);
    wr(REG_IO_HI, {28'h0, io[35:32]});
    wr(REG_CTRL, 32'h4);
    c = 1'b1;
    while (c !== 1'b0) begin
      rd(REG_CTRL);
      c = rd_d[CTRL_STEP];
      rd(REG_STATUS);
      c = c | rd_d[STAT_BUSY];
    end
    rd(REG_AC_LO);
    lo = rd_d;
    rd(REG_AC_HI);
    chk({rd_d[3:0], lo}, eac);
    rd(REG_IO_LO);
    lo = rd_d;
    rd(REG_IO_HI);
    chk({rd_d[3:0], lo}, eio);
    rd(REG_PC);
    chk({21'h0, rd_d[14:0]}, {21'h0, epc});
    chk(mem.m[15'h80], em);
    chk({35'h0, overflow}, {35'h0, ov});
  endtask : t

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t(w(OP_AND), 36'hc, 36'ha, 36'h8, 36'ha);
    t(w(OP_IOR), 36'hc, 36'ha, 36'he, 36'ha);
    t(w(OP_XOR), 36'hc, 36'ha, 36'h6, 36'ha);
    t(w(OP_ADD), 36'h5, 36'h3, 36'h8, 36'h3);
    t(w(OP_SUB), 36'h3, 36'h5, 36'hf_ffff_fffd, 36'h5);
    t(w(OP_MUL), 36'h3, 36'h5, 36'h0, 36'h5, P1, 1'b0, 36'h0, 36'hf);
    t(w(OP_DIV), 36'h0, 36'h2, 36'h1, 36'h2, P1, 1'b0, 36'h7, 36'h3);
    t(w(OP_DIV), 36'hf_ffff_ffff, 36'h2, 36'hf_ffff_fffe, 36'h2, P1,
      1'b0, 36'hf_ffff_fff8, 36'hf_ffff_fffc);
    t(w(OP_LAC), 36'h1, O, O, O);
    t(w(OP_DAC), A, O, A, A);
    t(w(OP_DAP), A, O, A, {O[35:18], A[17:0]});
    t(w(OP_DIP), A, O, A, {A[35:18], O[17:0]});
    t(w(OP_LIO), 36'h1, O, 36'h1, O, P1, 1'b0, 36'h1, O);
    t(w(OP_DIO), 36'h1, O, 36'h1, A, P1, 1'b0, A, A);
    t(w(OP_JMP), A, O, A, O, 15'h80);
    t(w(OP_JSP), A, O, A, O, 15'h80);
    rd(REG_IA);
    chk({21'h0, rd_d[14:0]}, {21'h0, P1});
    t(w(OP_DIA), A, O, A, {O[35:18], 18'h41});
    t(w(OP_SAD), 36'h1, 36'h2, 36'h1, 36'h2, P2);
    t(w(OP_SAS), 36'h2, 36'h2, 36'h2, 36'h2, P2);
    t(w(OP_SAD), 36'h2, 36'h2, 36'h2, 36'h2);
    t(w(OP_SAS), 36'h1, 36'h2, 36'h1, 36'h2);
    t(w(OP_SNX, 9'h80), A, 36'h5_5550_7f00, A, 36'h5_5550_7f80, P2);
    t(w(OP_SPX, 9'h80), A, 36'h5_5550_7f00, A, 36'h5_5550_7f80);
    t(w(OP_LIR, 9'h80, 15'h123), A, O, A, {O[35:18], 18'h123});
    t({OP_ROT_R, 3'h1, 27'h4}, 36'hf, O, 36'hf_0000_0000, O);
    t({OP_ROT_L, 3'h1, 27'h1}, 36'h8_0000_0001, O, 36'h3, O);
    t({OP_ROT_L, 3'h1, 27'h24}, A, O, A, O);
    mem.m[15'h30] = 36'h10;
    t(w(OP_LAC, 9'h30, 15'h70), A, O, O, O);
    mem.m[15'h60] = 36'h80;
    t(w(OP_LAC, 9'h0, 15'h60) | 36'h0_2000_0000, A, O, O, O);
    t(w(6'h08), A, O, A, O);
    wr(8'h24, 32'h0);
    chk({34'h0, rsp}, {34'h0, RESP_SLVERR});
    rd(8'h24);
    chk({34'h0, rsp}, {34'h0, RESP_SLVERR});
    t(w(OP_ADD), 36'h7_ffff_ffff, 36'h1, 36'h8_0000_0000, 36'h1, P1, 1'b1);
    t(w(OP_ADD), 36'h1, 36'h1, 36'h2, 36'h1, P1, 1'b1);
    t(w(OP_DIV), 36'h5, 36'h2, 36'h5, 36'h2, P1, 1'b1, 36'h7, 36'h7);
    // free run on a jump to itself, then stop
    mem.m[15'h41] = w(OP_JMP, 9'h0, 15'h41);
    wr(REG_CTRL, 32'h1);
    chk({35'h0, running}, 36'h1);
    chk({35'h0, overflow}, 36'h0);
    wr(REG_CTRL, 32'h2);
    chk({35'h0, running}, 36'h0);
    repeat (20) @(posedge aclk);
    rd(REG_PC);
    chk({21'h0, rd_d[14:0]}, {21'h0, P1});
    conclude();
  end
endmodule : tb_mre_exec
